// ### pcl_load.sv
// Divider program load logic: serial, parallel and hard-wired paths
`timescale 1ns/1ps
// Notes on behaviour
// - primary bits shift only while the serial load strobe is low; enhancement bits shift regardless of it.
// - rising load strobe loads the shifted word into both primary and secondary; hop write copies primary into secondary.
// - each shift clock rise shifts one bit into enhancement if enabled, else into primary while the load strobe is low.
// - serial mode counters use primary when serial source select high, else secondary.
// - parallel mode counters use primary when parallel source select high, else secondary.
// - enhancement write strobe rise captures all eight bus bits into enhancement.
// - main high nibble strobe rise loads bus bits 3:0 into ref 5:4, main 8:7.
// - main low byte strobe rise loads prescaler enable and main 6:0.
// - swallow strobe rise loads bus into ref 3:0 and swallow 3:0.
// - direct select low picks serial when serial select high, else parallel.
// - direct select high takes counter values straight from dedicated pins.
// - hard-wired main 6:0 and swallow 3:0 come from pins, bit 0 LSB.
// - prescaler enable is active low; high means prescaler bypassed.
// - enhancement bits act only while enhancement mode input is low.

////////////////////////////////////////////////////////////////////////////////

// Two-flop synchroniser for a bundle of quasi-static levels
module pcl_sync #(
  parameter int W = 1
) (
  input wire logic clk,          // Destination clock
  input wire logic nrst,         // Async reset, active low
  input wire logic [W-1:0] d,    // Asynchronous input
  output logic [W-1:0] q         // Synchronised output
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pcl_sync_st_t;

  pcl_sync_st_t st;
  pcl_sync_st_t next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st = st;
    next_st.meta = d;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;
endmodule

////////////////////////////////////////////////////////////////////////////////

// Shift registers clocked by the host's serial shift clock
module pcl_shift_link (
  input wire logic shift_clk,        // Serial shift clock from host
  input wire logic nrst,             // Async reset, active low
  input wire logic ser_data,         // Serial data bit
  input wire logic ser_load_n,       // Serial load strobe, shift while low
  input wire logic enh_write_enable, // High steers bits to enhancement
  output pcl_pkg::pcl_shift_t shift  // Shift register contents
);
  pcl_pkg::pcl_shift_t st;
  pcl_pkg::pcl_shift_t next_st;

  // Shift toward the MSB so the first bit lands on top
  always_comb begin
    next_st = st;
    if (enh_write_enable) begin
      next_st.enh = {st.enh[pcl_pkg::ENH_W-2:0], ser_data};
    end else if (!ser_load_n) begin
      next_st.pri = {st.pri[pcl_pkg::PRI_W-2:0], ser_data};
    end
  end

  // No edge is assumed outside a frame, the clock may stand still
  always_ff @(posedge shift_clk or negedge nrst) begin
    if (!nrst) begin
      st <= {pcl_pkg::PRI_RST, pcl_pkg::ENH_RST};
    end else begin
      st <= next_st;
    end
  end

  assign shift = st;
endmodule

////////////////////////////////////////////////////////////////////////////////

// Top: primary, secondary and enhancement registers and counter selection
module pcl_load (
  input wire logic sys_clk,                 // System clock, 100 MHz
  input wire logic nrst,                    // Async reset, active low
  input wire logic shift_clk,               // Serial shift clock from host
  input wire logic ser_data,                // Serial data bit
  input wire logic ser_load_n,              // Serial load strobe, active low
  input wire logic hop_write,               // Hop write strobe
  input wire logic enh_write_enable,        // Serial enhancement write enable
  input wire logic enh_write_strobe,        // Parallel enhancement write strobe
  input wire logic main_low_byte_strobe,    // Parallel main low byte write
  input wire logic main_high_nibble_strobe, // Parallel main high nibble write
  input wire logic swallow_strobe,          // Parallel swallow count write
  input wire logic [7:0] par_data,          // Parallel data bus
  input wire logic direct_sel,              // High selects hard-wired mode
  input wire logic serial_sel,              // High serial, low parallel
  input wire logic serial_source_select,    // Serial: 1 primary, 0 secondary
  input wire logic parallel_source_select,  // Parallel: 1 primary, 0 secondary
  input wire logic enh_mode_n,              // Enhancement bits live when low
  input wire logic [6:0] dir_main,          // Hard-wired main counter 6:0
  input wire logic [3:0] dir_swallow,       // Hard-wired swallow counter
  input wire logic [5:0] dir_ref,           // Hard-wired reference counter
  input wire logic dir_pre_en_n,            // Hard-wired prescaler enable
  output pcl_pkg::pcl_word_t cnt_word,      // Value driving the counters
  output logic prescaler_bypass,            // High routes input around prescaler
  output logic [7:0] enh_bits,              // Effective enhancement bits
  output pcl_pkg::pcl_mode_t mode           // Current interface mode
);
  typedef struct packed {
    pcl_pkg::pcl_pins_t prev;
    pcl_pkg::pcl_word_t primary;
    pcl_pkg::pcl_word_t secondary;
    logic [pcl_pkg::ENH_W-1:0] enh;
    pcl_pkg::pcl_word_t cnt_word;
    logic prescaler_bypass;
    logic [pcl_pkg::ENH_W-1:0] enh_bits;
    pcl_pkg::pcl_mode_t mode;
  } pcl_load_st_t;

  pcl_load_st_t st;
  pcl_load_st_t next_st;
  pcl_pkg::pcl_pins_t raw_pins;
  pcl_pkg::pcl_pins_t pins;
  pcl_pkg::pcl_shift_t shift;

  //////////////////////////////////////////////////////////////////////////////

  // Serial shifting lives on the host's clock
  pcl_shift_link u_link (
    .shift_clk(shift_clk),
    .nrst(nrst),
    .ser_data(ser_data),
    .ser_load_n(ser_load_n),
    .enh_write_enable(enh_write_enable),
    .shift(shift)
  );

  // Gather every host pin except the shift clock and serial data for the crossing
  always_comb begin
    raw_pins.ser_load_n = ser_load_n;
    raw_pins.hop_write = hop_write;
    raw_pins.enh_write_enable = enh_write_enable;
    raw_pins.enh_write_strobe = enh_write_strobe;
    raw_pins.main_low_byte_strobe = main_low_byte_strobe;
    raw_pins.main_high_nibble_strobe = main_high_nibble_strobe;
    raw_pins.swallow_strobe = swallow_strobe;
    raw_pins.direct_sel = direct_sel;
    raw_pins.serial_sel = serial_sel;
    raw_pins.serial_source_select = serial_source_select;
    raw_pins.parallel_source_select = parallel_source_select;
    raw_pins.enh_mode_n = enh_mode_n;
    raw_pins.par_data = par_data;
    raw_pins.dir_main = dir_main;
    raw_pins.dir_swallow = dir_swallow;
    raw_pins.dir_ref = dir_ref;
    raw_pins.dir_pre_en_n = dir_pre_en_n;
  end

  // Strobes and data share one synchroniser so they stay aligned
  pcl_sync #(
    .W($bits(pcl_pkg::pcl_pins_t))
  ) u_sync (
    .clk(sys_clk),
    .nrst(nrst),
    .d(raw_pins),
    .q(pins)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Register updates on synchronised strobe edges
  always_comb begin
    logic load_rise;
    logic hop_rise;
    logic enh_en_fall;
    logic enh_rise;
    logic m1_rise;
    logic m2_rise;
    logic a_rise;
    pcl_pkg::pcl_m1_byte_t m1_byte;
    pcl_pkg::pcl_m2_byte_t m2_byte;
    pcl_pkg::pcl_a_byte_t a_byte;
    load_rise = pins.ser_load_n && !st.prev.ser_load_n;
    hop_rise = pins.hop_write && !st.prev.hop_write;
    enh_en_fall = !pins.enh_write_enable && st.prev.enh_write_enable;
    enh_rise = pins.enh_write_strobe && !st.prev.enh_write_strobe;
    m1_rise = pins.main_low_byte_strobe && !st.prev.main_low_byte_strobe;
    m2_rise = pins.main_high_nibble_strobe && !st.prev.main_high_nibble_strobe;
    a_rise = pins.swallow_strobe && !st.prev.swallow_strobe;
    m1_byte = pins.par_data;
    m2_byte = pins.par_data;
    a_byte = pins.par_data;
    next_st = st;
    next_st.prev = pins;

    // Mode decode, direct select overrides the serial select
    if (pins.direct_sel) begin
      next_st.mode = pcl_pkg::PCL_DIRECT;
    end else if (pins.serial_sel) begin
      next_st.mode = pcl_pkg::PCL_SERIAL;
    end else begin
      next_st.mode = pcl_pkg::PCL_PARALLEL;
    end

    // Serial path: shift word is stable once the load strobe is high
    if (st.mode == pcl_pkg::PCL_SERIAL) begin
      if (load_rise) begin
        next_st.primary = shift.pri;
        next_st.secondary = shift.pri;
      end else if (hop_rise) begin
        next_st.secondary = st.primary;
      end
      if (enh_en_fall) begin
        next_st.enh = shift.enh;
      end
    end

    // Parallel path: byte writes into fields of the primary word
    if (st.mode == pcl_pkg::PCL_PARALLEL) begin
      if (m1_rise) begin
        next_st.primary.pre_en_n = m1_byte.pre_en_n;
        next_st.primary.main_div[6:0] = m1_byte.main_lo;
      end
      if (m2_rise) begin
        next_st.primary.ref_div[5:4] = m2_byte.ref_hi;
        next_st.primary.main_div[8:7] = m2_byte.main_hi;
      end
      if (a_rise) begin
        next_st.primary.ref_div[3:0] = a_byte.ref_lo;
        next_st.primary.swallow = a_byte.swallow;
      end
      if (enh_rise) begin
        next_st.enh = pins.par_data;
      end
      // Hop copies the word as it stood before this cycle's byte writes
      if (hop_rise) begin
        next_st.secondary = st.primary;
      end
    end

    // Counter source follows the mode and the source selects
    unique case (next_st.mode)
      pcl_pkg::PCL_SERIAL: begin
        next_st.cnt_word = pins.serial_source_select ?
          next_st.primary : next_st.secondary;
      end
      pcl_pkg::PCL_PARALLEL: begin
        next_st.cnt_word = pins.parallel_source_select ?
          next_st.primary : next_st.secondary;
      end
      pcl_pkg::PCL_DIRECT: begin
        next_st.cnt_word.pre_en_n = pins.dir_pre_en_n;
        next_st.cnt_word.ref_div = pins.dir_ref;
        next_st.cnt_word.main_div = {{pcl_pkg::DIR_MAIN_PAD{1'b0}}, pins.dir_main};
        next_st.cnt_word.swallow = pins.dir_swallow;
      end
    endcase

    // Active low enable, so a high level bypasses the prescaler
    next_st.prescaler_bypass = next_st.cnt_word.pre_en_n;

    // Enhancement bits have no effect outside enhancement mode or in direct mode
    if (!pins.enh_mode_n && next_st.mode != pcl_pkg::PCL_DIRECT) begin
      next_st.enh_bits = next_st.enh;
    end else begin
      next_st.enh_bits = pcl_pkg::ENH_RST;
    end
  end

  // Single state register for the system domain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st.prev <= '0;
      st.primary <= pcl_pkg::PRI_RST;
      st.secondary <= pcl_pkg::PRI_RST;
      st.enh <= pcl_pkg::ENH_RST;
      st.cnt_word <= pcl_pkg::PRI_RST;
      st.prescaler_bypass <= 1'b0;
      st.enh_bits <= pcl_pkg::ENH_RST;
      st.mode <= pcl_pkg::PCL_PARALLEL;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign cnt_word = st.cnt_word;
  assign prescaler_bypass = st.prescaler_bypass;
  assign enh_bits = st.enh_bits;
  assign mode = st.mode;
endmodule

// ### pcl_pkg.sv
// Shared constants and types for the synthesizer divider load logic
package pcl_pkg;

  // Register widths
  localparam int PRI_W = 20;
  localparam int ENH_W = 8;
  localparam int DATA_W = 8;

  // Bit positions inside the 20-bit primary word, highest shifts in first
  localparam int PRI_PRE_BIT = 19;
  localparam int PRI_REF_LSB = 13;
  localparam int PRI_MAIN_LSB = 4;
  localparam int PRI_SWALLOW_LSB = 0;

  // Values after reset
  localparam logic [PRI_W-1:0] PRI_RST = 20'h00000;
  localparam logic [ENH_W-1:0] ENH_RST = 8'h00;

  // Width of the unused high part of the main counter in hard-wired mode
  localparam int DIR_MAIN_PAD = 2;

  // Primary and secondary word, field order matches the bit positions
  typedef struct packed {
    logic pre_en_n;      // Prescaler enable, active low
    logic [5:0] ref_div; // Reference counter
    logic [8:0] main_div; // Main counter
    logic [3:0] swallow; // Swallow counter
  } pcl_word_t;

  // Byte layout of the main low byte write
  typedef struct packed {
    logic pre_en_n;
    logic [6:0] main_lo;
  } pcl_m1_byte_t;

  // Byte layout of the main high nibble write
  typedef struct packed {
    logic [3:0] unused;
    logic [1:0] ref_hi;
    logic [1:0] main_hi;
  } pcl_m2_byte_t;

  // Byte layout of the swallow count write
  typedef struct packed {
    logic [3:0] ref_lo;
    logic [3:0] swallow;
  } pcl_a_byte_t;

  // Interface mode
  typedef enum logic [1:0] {
    PCL_SERIAL,
    PCL_PARALLEL,
    PCL_DIRECT
  } pcl_mode_t;

  // Host pins seen by the system clock domain
  typedef struct packed {
    logic ser_load_n;
    logic hop_write;
    logic enh_write_enable;
    logic enh_write_strobe;
    logic main_low_byte_strobe;
    logic main_high_nibble_strobe;
    logic swallow_strobe;
    logic direct_sel;
    logic serial_sel;
    logic serial_source_select;
    logic parallel_source_select;
    logic enh_mode_n;
    logic [DATA_W-1:0] par_data;
    logic [6:0] dir_main;
    logic [3:0] dir_swallow;
    logic [5:0] dir_ref;
    logic dir_pre_en_n;
  } pcl_pins_t;

  // Shift registers of the link domain
  typedef struct packed {
    logic [PRI_W-1:0] pri;
    logic [ENH_W-1:0] enh;
  } pcl_shift_t;

endpackage

// ### pcl_load_sva.sv
// Port checker for the divider load block
`timescale 1ns/1ps
module pcl_load_sva (
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Reset
  input wire logic ser_load_n, // Load strobe
  input wire logic hop_write, // Hop strobe
  input wire logic main_low_byte_strobe, // M low write
  input wire logic main_high_nibble_strobe, // M high write
  input wire logic swallow_strobe, // Swallow write
  input wire logic [7:0] par_data, // Bus
  input wire logic direct_sel, // Direct mode
  input wire logic serial_sel, // Serial mode
  input wire logic serial_source_select, // Serial source
  input wire logic parallel_source_select, // Parallel source
  input wire logic enh_mode_n, // Enh live low
  input wire logic [6:0] dir_main, // Pins
  input wire logic [3:0] dir_swallow, // Pins
  input wire logic [5:0] dir_ref, // Pins
  input wire logic dir_pre_en_n, // Pin
  input pcl_pkg::pcl_word_t cnt_word, // Counter word
  input wire logic prescaler_bypass, // Bypass
  input wire logic [7:0] enh_bits, // Enh bits
  input pcl_pkg::pcl_mode_t mode // Mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  // Strobe rise with data held long enough to clear both sync flops
  sequence s_wr(s);
    $rose(s) && mode == pcl_pkg::PCL_PARALLEL && parallel_source_select
      ##1 ($stable(par_data) && parallel_source_select && !direct_sel && !serial_sel) [*4];
  endsequence
  sequence s_dir;
    (direct_sel && $stable({dir_main, dir_swallow, dir_ref, dir_pre_en_n})) [*5];
  endsequence
  property p_m1;
    s_wr(main_low_byte_strobe) |-> {cnt_word.pre_en_n, cnt_word.main_div[6:0]} == par_data;
  endproperty
  property p_m2;
    s_wr(main_high_nibble_strobe) |->
      {cnt_word.ref_div[5:4], cnt_word.main_div[8:7]} == par_data[3:0];
  endproperty
  property p_sw;
    s_wr(swallow_strobe) |-> {cnt_word.ref_div[3:0], cnt_word.swallow} == par_data;
  endproperty
  property p_dir;
    s_dir |-> cnt_word == {dir_pre_en_n, dir_ref, 2'b00, dir_main, dir_swallow}
      && mode == pcl_pkg::PCL_DIRECT && enh_bits == 8'h00;
  endproperty
  property p_ser;
    (!direct_sel && serial_sel) [*5] |-> mode == pcl_pkg::PCL_SERIAL;
  endproperty
  property p_par;
    (!direct_sel && !serial_sel) [*5] |-> mode == pcl_pkg::PCL_PARALLEL;
  endproperty
  property p_enh_off;
    enh_mode_n [*5] |-> enh_bits == 8'h00;
  endproperty
  property p_byp;
    s_dir |-> prescaler_bypass == dir_pre_en_n;
  endproperty
  // Parallel strobes and shifting must not disturb the serial counters
  property p_ser_hold;
    (mode == pcl_pkg::PCL_SERIAL && !hop_write && $stable(ser_load_n)
      && $stable(serial_source_select)) [*6] |-> $stable(cnt_word);
  endproperty
  a_m1: assert property (p_m1) else $error("main low byte capture wrong");
  a_m2: assert property (p_m2) else $error("main high nibble capture wrong");
  a_sw: assert property (p_sw) else $error("swallow capture wrong");
  a_dir: assert property (p_dir) else $error("direct pin value wrong");
  a_ser: assert property (p_ser) else $error("serial mode not entered");
  a_par: assert property (p_par) else $error("parallel mode not entered");
  a_enh_off: assert property (p_enh_off) else $error("enh bits live while off");
  a_byp: assert property (p_byp) else $error("bypass not from enable");
  a_ser_hold: assert property (p_ser_hold) else $error("serial word moved");
endmodule

// ### pcl_host.sv
// Host model driving the serial link
`timescale 1ns/1ps
module pcl_host (
  output logic shift_clk, // Link clock, still between frames
  output logic ser_data, // Serial data
  output logic ser_load_n, // Load strobe
  output logic enh_write_enable // Enhancement steer
);
  initial begin
    {shift_clk, ser_data, ser_load_n, enh_write_enable} = 4'h2;
  end
  ////////////////////////////////////////////////////////////
  // 6 ns link period; data inverted after a frame so stale bits never look valid
  task automatic shift_bits(input logic [19:0] w, input int n);
    #1.7;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = w[i];
      #3 shift_clk = 1'b1;
      #3 shift_clk = 1'b0;
    end
    ser_data = ~ser_data;
  endtask
  // Stray edges land before the load is seen, so a leak corrupts the word
  task automatic load_word(input logic [19:0] w, input int n_stray);
    ser_load_n = 1'b0;
    shift_bits(w, 20);
    #6 ser_load_n = 1'b1;
    shift_bits(~w, n_stray);
    #60;
  endtask
  task automatic load_enh(input logic [7:0] e);
    enh_write_enable = 1'b1;
    shift_bits({12'h000, e}, 8);
    #6 enh_write_enable = 1'b0;
    #60;
  endtask
endmodule

// ### tb_top.sv
// Top bench comparing the load block with a reference model
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic nrst, shift_clk, ser_data, ser_load_n, enh_write_enable, hop_write;
  logic enh_write_strobe, main_low_byte_strobe, main_high_nibble_strobe, swallow_strobe;
  logic direct_sel, serial_sel, serial_source_select, parallel_source_select, enh_mode_n;
  logic dir_pre_en_n, prescaler_bypass;
  logic [7:0] par_data, enh_bits, enh;
  logic [6:0] dir_main;
  logic [3:0] dir_swallow;
  logic [5:0] dir_ref;
  logic [19:0] pri, sec, w;
  pcl_pkg::pcl_word_t cnt_word;
  pcl_pkg::pcl_mode_t mode;
  int seed = 18481;
  int n_errors = 0;
  int samples_checked = 0;
  pcl_load i_pcl_load (.*);
  pcl_host i_pcl_host (.*);
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Byte write; model only moves in parallel mode since other modes refuse it
  task automatic pwr(input int s, input logic [7:0] d);
    par_data = d;
    cyc(3);
    {enh_write_strobe, swallow_strobe, main_high_nibble_strobe, main_low_byte_strobe} = 4'h1 << s;
    cyc(5);
    {enh_write_strobe, swallow_strobe, main_high_nibble_strobe, main_low_byte_strobe} = 4'h0;
    cyc(4);
    if (!serial_sel && !direct_sel) begin
      case (s)
        0: {pri[19], pri[10:4]} = d;
        1: {pri[18:17], pri[12:11]} = d[3:0];
        2: {pri[16:13], pri[3:0]} = d;
        default: enh = d;
      endcase
    end
  endtask
  // Bounded run guard
  initial begin
    #200000;
    n_errors++;
    $display("[FAIL] %0t run timed out", $time);
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    {hop_write, enh_write_strobe, main_low_byte_strobe, main_high_nibble_strobe} = 4'h0;
    {swallow_strobe, enh_mode_n, par_data, pri, sec, enh} = '0;
    {direct_sel, serial_sel, serial_source_select, parallel_source_select} = 4'h1;
    {dir_pre_en_n, dir_ref, dir_main, dir_swallow} = '0;
    repeat (12) @(posedge sys_clk);
    chk(cnt_word, 20'h00000);
    @(negedge sys_clk) nrst = 1'b1;
    cyc(4);
    // Parallel writes of all three bytes, random data
    for (int i = 0; i < 4; i++) begin
      pwr(0, 8'($random(seed)));
      pwr(1, 8'($random(seed)));
      pwr(2, 8'($random(seed)));
      chk(cnt_word, pri);
      chk({19'h0, prescaler_bypass}, {19'h0, pri[19]});
    end
    hop_write = 1'b1;
    cyc(5);
    hop_write = 1'b0;
    sec = pri;
    pwr(0, 8'h5A);
    parallel_source_select = 1'b0;
    cyc(6);
    chk(cnt_word, sec);
    pwr(3, 8'hC3);
    chk({12'h0, enh_bits}, {12'h0, enh});
    enh_mode_n = 1'b1;
    cyc(6);
    chk({12'h0, enh_bits}, 20'h00000);
    enh_mode_n = 1'b0;
    $display("Test parallel done");
    // Serial mode shares primary; secondary keeps the older word
    serial_sel = 1'b1;
    cyc(6);
    chk(cnt_word, sec);
    serial_source_select = 1'b1;
    pwr(0, 8'($random(seed)));
    chk(cnt_word, pri);
    for (int i = 0; i < 3; i++) begin
      w = 20'($random(seed));
      serial_source_select = i[0];
      i_pcl_host.load_word(w, 4);
      pri = w;
      sec = w;
      cyc(2);
      chk(cnt_word, sec);
    end
    i_pcl_host.load_enh(8'h96);
    cyc(2);
    chk({12'h0, enh_bits}, 20'h00096);
    $display("Test serial done");
    direct_sel = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {dir_pre_en_n, dir_ref, dir_main, dir_swallow} = 18'($random(seed));
      cyc(6);
      chk(cnt_word, {dir_pre_en_n, dir_ref, 2'b00, dir_main, dir_swallow});
      chk({18'h0, mode}, {18'h0, pcl_pkg::PCL_DIRECT});
    end
    $display("Test direct done");
    finish_test();
  end
endmodule
bind pcl_load pcl_load_sva i_pcl_load_sva (.*);
